// File: design/cmg_gateway.sv
//Contract
//- No CAN traffic unless a valid stored configuration is present.
//- Configuration-mode pin is sampled once after power-up only.
//- Module indicator flashes green while in configuration mode.
//- Baud code 00..08 maps to 1000..10 kbit/s.
//- 11-bit frames: accept all, list only, or none.
//- 29-bit frames: independent accept all, list only, or none.
//- Configuration enables evaluation of stop and exchange-halt bits.
//- Exactly one transmission mode, confirmed or not, from configuration.
//- Unconfirmed mode passes fresh data each cycle without acknowledgement.
//- Confirmed mode holds data until the receiver confirms.
//- Frames pass transparently through the process-data channel.
//- Packets initialise, start, stop, send and set receive filters.
//- Controller status including bus-off is reported to the host.
//- Message is data bytes plus 2 or 4 identifier bytes.
//- Packet starts with length and command nibbles, then id, data.
//- Bus-to-host record spans both sub-channels consistently.
//- Host-to-bus record acted on only when both halves agree.
//- Halt bits ignored unless their evaluation is enabled.
//- Sequence ids 0..E, next packet only after echo; the code waits for the echo in confirmed mode only.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cmg_gateway import cmg_pkg::*; #(
    parameter int unsigned BLINK_CYC = BLINK_HALF_CYC
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic mode_pin,
    input wire logic nv_present_pin,
    output logic nv_rd,
    output logic [1:0] nv_addr,
    input wire logic [15:0] nv_rdata,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic can_tx_valid,
    input wire logic can_tx_ready,
    output logic [28:0] can_tx_id,
    output logic can_tx_ide,
    output logic can_tx_rtr,
    output logic [3:0] can_tx_dlc,
    output logic [63:0] can_tx_data,
    input wire logic can_rx_valid,
    output logic can_rx_ready,
    input wire logic [28:0] can_rx_id,
    input wire logic can_rx_ide,
    input wire logic can_rx_rtr,
    input wire logic [3:0] can_rx_dlc,
    input wire logic [63:0] can_rx_data,
    input wire logic can_bus_off,
    input wire logic can_err_warn,
    output logic can_enable,
    output logic [15:0] can_baud_kbps,
    output logic md_green,
    output logic md_red
);
    logic [1:0] sync1_q, sync2_q;
    logic [1:0] pwr_cnt_q;
    logic mode_taken_q, cfg_mode_q;
    logic ld_done, ld_ok, blink;
    logic [7:0] cfg_flags, cfg_baud;
    logic [1:0] ctrl_q;
    logic [17:0] txa_q;
    logic [28:0] txid_q;
    logic [63:0] txd_q;
    logic [3:0] last_seq_q, rx_seq_q;
    logic started_q, tx_pend_q, rx_hold_q;
    logic [30:0] flt_q [FLT_N];
    logic [28:0] rx_id_q;
    logic rx_ide_q, rx_rtr_q;
    logic [3:0] rx_dlc_q;
    logic [63:0] rx_data_q;
    logic [31:0] rd_d;

    // Pins from outside the clock domain
    always_ff @(posedge clock) begin
        if (srst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {nv_present_pin, mode_pin};
            sync2_q <= sync1_q;
        end
    end

    // Mode latched once the synchroniser has filled; later pin changes
    // are deliberately ignored until the next power cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            pwr_cnt_q <= '0;
            mode_taken_q <= 1'b0;
            cfg_mode_q <= 1'b0;
        end else if (!mode_taken_q) begin
            pwr_cnt_q <= pwr_cnt_q + 2'h1;
            if (pwr_cnt_q == SYNC_LAT) begin
                mode_taken_q <= 1'b1;
                cfg_mode_q <= sync2_q[0];
            end
        end
    end

    cmg_cfg_load u_load (
        .clock(clock),
        .srst(srst),
        .start(mode_taken_q),
        .present(sync2_q[1]),
        .nv_rd(nv_rd),
        .nv_addr(nv_addr),
        .nv_rdata(nv_rdata),
        .done(ld_done),
        .ok(ld_ok),
        .flags(cfg_flags),
        .baud(cfg_baud)
    );

    cmg_blink #(.HALF_CYC(BLINK_CYC)) u_blink (
        .clock(clock),
        .srst(srst),
        .blink(blink)
    );

    wire cfg_ok = ld_done && ld_ok && !cfg_mode_q;
    wire conf = cfg_flags[CF_CONF];
    wire [1:0] pol11 = cfg_flags[CF_F11 +: 2];
    wire [1:0] pol29 = cfg_flags[CF_F29 +: 2];
    wire peh_eff = cfg_flags[CF_PEH] && ctrl_q[CTL_PEH];
    wire stop_eff = cfg_flags[CF_STOP] && ctrl_q[CTL_STOP];
    wire can_run = cfg_ok && started_q && !stop_eff && !peh_eff;

    // Indicator: flashing green for configuration, flashing red for
    // a missing or bad image, steady green when ready
    assign md_green = mode_taken_q && (cfg_mode_q ? blink : cfg_ok);
    assign md_red = ld_done && !cfg_mode_q && !ld_ok && blink;

    // Register decode
    wire wr_ctrl = reg_wr && (reg_addr == A_CTRL);
    wire wr_txa = reg_wr && (reg_addr == A_TXA);
    wire wr_txid = reg_wr && (reg_addr == A_TXID);
    wire wr_txd0 = reg_wr && (reg_addr == A_TXD0);
    wire wr_txd1 = reg_wr && (reg_addr == A_TXD1);
    wire wr_txb = reg_wr && (reg_addr == A_TXB);

    // Host-to-bus record, closed by the second sub-channel
    wire [3:0] a_seq = txa_q[REC_SEQ +: 4];
    wire [3:0] a_ack = txa_q[REC_ACK +: 4];
    wire [3:0] a_cmd = txa_q[REC_LC +: 4];
    wire [3:0] a_len = txa_q[REC_LC + 4 +: 4];
    wire a_ide = txa_q[REC_IDE];
    wire rec_ok = wr_txb && (reg_wdata[REC_SEQ +: 4] == a_seq)
        && (reg_wdata[REC_ACK +: 4] == a_ack) && (a_seq <= SEQ_MAX);
    // Confirmed mode: a repeated id is the same packet again
    wire rec_new = !conf || (a_seq != last_seq_q);
    wire take = rec_ok && cfg_ok && !peh_eff && rec_new
        && !(conf && tx_pend_q);
    wire [3:0] idb = a_ide ? IDB29 : IDB11;
    wire [3:0] a_dlc = a_len - idb;
    wire len_ok = (a_len >= idb) && (a_dlc <= DLC_MAX);
    wire take_send = take && (a_cmd == CMD_SEND) && len_ok && can_run;
    wire tx_done = can_tx_valid && can_tx_ready;

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_q <= '0;
            txa_q <= '0;
            txid_q <= '0;
            txd_q <= '0;
        end else begin
            if (wr_ctrl) ctrl_q <= reg_wdata[1:0];
            if (wr_txa) txa_q <= reg_wdata[17:0];
            if (wr_txid) txid_q <= reg_wdata[28:0];
            if (wr_txd0) txd_q[31:0] <= reg_wdata;
            if (wr_txd1) txd_q[63:32] <= reg_wdata;
        end
    end

    // Packet commands
    always_ff @(posedge clock) begin
        if (srst) begin
            started_q <= 1'b1;
            last_seq_q <= SEQ_RST;
            for (int i = 0; i < FLT_N; i++) flt_q[i] <= '0;
        end else if (take) begin
            last_seq_q <= a_seq;
            unique case (a_cmd)
                CMD_INIT: begin
                    started_q <= 1'b0;
                    for (int i = 0; i < FLT_N; i++) flt_q[i] <= '0;
                end
                CMD_START: started_q <= 1'b1;
                CMD_STOP: started_q <= 1'b0;
                CMD_FILT: flt_q[txd_q[1:0]] <= {1'b1, a_ide, txid_q};
                default: ;
            endcase
        end
    end

    // Outgoing frame; unconfirmed mode may overwrite an unsent one
    always_ff @(posedge clock) begin
        if (srst) begin
            tx_pend_q <= 1'b0;
            can_tx_id <= '0;
            can_tx_ide <= 1'b0;
            can_tx_rtr <= 1'b0;
            can_tx_dlc <= '0;
            can_tx_data <= '0;
        end else begin
            if (take_send) begin
                tx_pend_q <= 1'b1;
                can_tx_id <= a_ide ? txid_q : {18'h0, txid_q[10:0]};
                can_tx_ide <= a_ide;
                can_tx_rtr <= txa_q[REC_RTR];
                can_tx_dlc <= a_dlc;
                can_tx_data <= txd_q;
            end else if (tx_done) begin
                tx_pend_q <= 1'b0;
            end
        end
    end
    assign can_tx_valid = tx_pend_q && can_run;
    assign can_enable = can_run;

    // Receive filtering
    logic [FLT_N-1:0] hit;
    wire [28:0] rx_key = can_rx_ide ? can_rx_id : {18'h0, can_rx_id[10:0]};
    generate
        for (genvar i = 0; i < FLT_N; i++) begin : g_flt
            assign hit[i] = flt_q[i][FLT_V]
                && (flt_q[i][FLT_IDE] == can_rx_ide)
                && (flt_q[i][28:0] == rx_key);
        end
    endgenerate
    wire [1:0] pol = can_rx_ide ? pol29 : pol11;
    wire rx_acc = (pol == POL_ALL) || ((pol == POL_LIST) && (|hit));
    assign can_rx_ready = can_run && !(conf && rx_hold_q);
    wire rx_fire = can_rx_valid && can_rx_ready;
    wire host_echo = rec_ok && (a_ack == rx_seq_q);

    // Bus-to-host record; confirmed mode freezes it until echoed
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_seq_q <= SEQ_RST;
            rx_hold_q <= 1'b0;
            rx_id_q <= '0;
            rx_ide_q <= 1'b0;
            rx_rtr_q <= 1'b0;
            rx_dlc_q <= '0;
            rx_data_q <= '0;
        end else if (rx_fire && rx_acc) begin
            rx_seq_q <= (rx_seq_q >= SEQ_MAX) ? 4'h0 : rx_seq_q + 4'h1;
            rx_hold_q <= conf;
            rx_id_q <= rx_key;
            rx_ide_q <= can_rx_ide;
            rx_rtr_q <= can_rx_rtr;
            rx_dlc_q <= can_rx_dlc;
            rx_data_q <= can_rx_data;
        end else if (host_echo) begin
            rx_hold_q <= 1'b0;
        end
    end

    // Both halves read the same registers, so they always agree
    wire [3:0] rx_len = rx_dlc_q + (rx_ide_q ? IDB29 : IDB11);
    wire [31:0] rec_b = {24'h0, last_seq_q, rx_seq_q};
    wire [31:0] rec_a = {14'h0, rx_ide_q, rx_rtr_q, rx_len, CMD_RXD,
        last_seq_q, rx_seq_q};
    wire [31:0] stat = {24'h0, conf, rx_hold_q, tx_pend_q, can_err_warn,
        can_bus_off, started_q, cfg_mode_q, cfg_ok};

    always_comb begin
        case (reg_addr)
            A_CTRL: rd_d = {30'h0, ctrl_q};
            A_STAT: rd_d = stat;
            A_BAUD: rd_d = {16'h0, can_baud_kbps};
            A_TXA: rd_d = {14'h0, txa_q};
            A_RXA: rd_d = rec_a;
            A_RXID: rd_d = {3'h0, rx_id_q};
            A_RXD0: rd_d = rx_data_q[31:0];
            A_RXD1: rd_d = rx_data_q[63:32];
            A_RXB: rd_d = rec_b;
            default: rd_d = '0;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= '0;
            can_baud_kbps <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_d : '0;
            can_baud_kbps <= cmg_baud_kbps(cfg_baud);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    AST_NO_CFG: assert property (!cfg_ok |->
        !can_enable && !can_tx_valid && !can_rx_ready)
        else $error("CAN active without valid configuration");
    AST_MODE_HOLD: assert property (mode_taken_q |=>
        $stable(cfg_mode_q) && mode_taken_q)
        else $error("mode changed after power-up");
    AST_MD_FLASH: assert property (mode_taken_q && cfg_mode_q |->
        md_green == blink && !md_red)
        else $error("indicator not flashing in configuration mode");
    AST_BAUD500: assert property (cfg_baud == 8'h02 ##1 cfg_baud == 8'h02
        |-> can_baud_kbps == 16'd500)
        else $error("baud code 02 not decoded as 500");
    AST_F11_NONE: assert property (rx_fire && !can_rx_ide && pol11 == POL_NONE
        |=> $stable(rx_seq_q))
        else $error("11-bit frame accepted with policy none");
    AST_F29_ALL: assert property (rx_fire && can_rx_ide && pol29 == POL_ALL
        && !host_echo |=> rx_ide_q && rx_seq_q != $past(rx_seq_q))
        else $error("29-bit frame dropped with policy all");
    AST_HALT_IGN: assert property (!cfg_flags[CF_PEH] && !cfg_flags[CF_STOP]
        && cfg_ok && started_q |-> can_enable)
        else $error("halt bit acted on while not enabled");
    AST_TX_HOLD: assert property (conf && tx_pend_q && !can_tx_ready |=>
        tx_pend_q && $stable(can_tx_data) && $stable(can_tx_id))
        else $error("confirmed frame changed before acceptance");
    AST_RX_HOLD: assert property (conf && rx_hold_q |->
        !can_rx_ready ##1 (rx_hold_q || $past(host_echo)))
        else $error("new record before host echo");
    AST_BUSOFF: assert property (reg_rd && reg_addr == A_STAT && can_bus_off
        |=> reg_rdata[ST_BOFF])
        else $error("bus-off not reported");
endmodule
`default_nettype wire

// File: design/cmg_pkg.sv
package cmg_pkg;
    // Clock and indicator timing
    localparam int CLK_NS = 8;
    localparam int BLINK_HALF_NS = 250_000_000;
    localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_NS;
    localparam logic [1:0] SYNC_LAT = 2'h3;

    // Register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_BAUD = 8'h08;
    localparam logic [7:0] A_TXA = 8'h10;
    localparam logic [7:0] A_TXID = 8'h14;
    localparam logic [7:0] A_TXD0 = 8'h18;
    localparam logic [7:0] A_TXD1 = 8'h1C;
    localparam logic [7:0] A_TXB = 8'h20;
    localparam logic [7:0] A_RXA = 8'h30;
    localparam logic [7:0] A_RXID = 8'h34;
    localparam logic [7:0] A_RXD0 = 8'h38;
    localparam logic [7:0] A_RXD1 = 8'h3C;
    localparam logic [7:0] A_RXB = 8'h40;

    // Command word bits
    localparam int CTL_PEH = 0;
    localparam int CTL_STOP = 1;

    // Sub-channel record fields
    localparam int REC_SEQ = 0;
    localparam int REC_ACK = 4;
    localparam int REC_LC = 8;
    localparam int REC_RTR = 16;
    localparam int REC_IDE = 17;
    localparam logic [3:0] SEQ_MAX = 4'hE;
    localparam logic [3:0] SEQ_RST = 4'hF;

    // Status bits
    localparam int ST_OK = 0;
    localparam int ST_MODE = 1;
    localparam int ST_RUN = 2;
    localparam int ST_BOFF = 3;
    localparam int ST_WARN = 4;
    localparam int ST_TXP = 5;
    localparam int ST_RXH = 6;
    localparam int ST_CONF = 7;

    // Packet command codes
    localparam logic [3:0] CMD_SEND = 4'h1;
    localparam logic [3:0] CMD_INIT = 4'h2;
    localparam logic [3:0] CMD_START = 4'h3;
    localparam logic [3:0] CMD_STOP = 4'h4;
    localparam logic [3:0] CMD_FILT = 4'h5;
    localparam logic [3:0] CMD_RXD = 4'h6;
    localparam logic [3:0] IDB11 = 4'h2;
    localparam logic [3:0] IDB29 = 4'h4;
    localparam logic [3:0] DLC_MAX = 4'h8;

    // Filter policies and list
    localparam logic [1:0] POL_ALL = 2'h0;
    localparam logic [1:0] POL_LIST = 2'h1;
    localparam logic [1:0] POL_NONE = 2'h2;
    localparam int FLT_N = 4;
    localparam int FLT_V = 30;
    localparam int FLT_IDE = 29;

    // Stored configuration image
    localparam int CFG_WORDS = 3;
    localparam logic [1:0] CW_MAGIC = 2'h0;
    localparam logic [1:0] CW_FLAGS = 2'h1;
    localparam logic [1:0] CW_BAUD = 2'h2;
    localparam logic [15:0] CFG_MAGIC = 16'hA5C3;
    localparam int CF_PEH = 0;
    localparam int CF_STOP = 1;
    localparam int CF_CONF = 2;
    localparam int CF_F11 = 4;
    localparam int CF_F29 = 6;
    localparam logic [7:0] BAUD_MAX = 8'h08;

    function automatic logic [15:0] cmg_baud_kbps(input logic [7:0] code);
        case (code)
            8'h00: return 16'h03E8;
            8'h01: return 16'h0320;
            8'h02: return 16'h01F4;
            8'h03: return 16'h00FA;
            8'h04: return 16'h007D;
            8'h05: return 16'h0064;
            8'h06: return 16'h0032;
            8'h07: return 16'h0014;
            8'h08: return 16'h000A;
            default: return 16'h0000;
        endcase
    endfunction
endpackage

// File: design/cmg_blink.sv
`timescale 1ns/1ps
`default_nettype none
module cmg_blink import cmg_pkg::*; #(
    parameter int unsigned HALF_CYC = BLINK_HALF_CYC
) (
    input wire logic clock,
    input wire logic srst,
    output logic blink
);
    logic [31:0] cnt_q;
    logic blink_q;

    // Even duty cycle flashing
    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_q <= '0;
            blink_q <= 1'b0;
        end else if (cnt_q >= HALF_CYC - 1) begin
            cnt_q <= '0;
            blink_q <= ~blink_q;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end
    assign blink = blink_q;
endmodule
`default_nettype wire

// File: design/cmg_cfg_load.sv
`timescale 1ns/1ps
`default_nettype none
module cmg_cfg_load import cmg_pkg::*; (
    input wire logic clock,
    input wire logic srst,
    input wire logic start,
    input wire logic present,
    output logic nv_rd,
    output logic [1:0] nv_addr,
    input wire logic [15:0] nv_rdata,
    output logic done,
    output logic ok,
    output logic [7:0] flags,
    output logic [7:0] baud
);
    typedef enum logic [1:0] {LD_IDLE, LD_REQ, LD_WAIT, LD_DONE} cmg_ld_e;
    cmg_ld_e st_q;
    logic [1:0] idx_q;
    logic [15:0] word_q [CFG_WORDS];
    logic [1:0] pol11, pol29;
    logic ok_w;

    assign nv_rd = (st_q == LD_REQ) && present;
    assign nv_addr = idx_q;
    assign pol11 = word_q[CW_FLAGS][CF_F11 +: 2];
    assign pol29 = word_q[CW_FLAGS][CF_F29 +: 2];
    // Any damaged field means no usable image
    assign ok_w = (word_q[CW_MAGIC] == CFG_MAGIC)
        && (word_q[CW_BAUD][7:0] <= BAUD_MAX)
        && (pol11 != 2'h3) && (pol29 != 2'h3);

    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= LD_IDLE;
            idx_q <= '0;
            ok <= 1'b0;
            for (int i = 0; i < CFG_WORDS; i++) word_q[i] <= '0;
        end else begin
            unique case (st_q)
                LD_IDLE: if (start) st_q <= LD_REQ;
                LD_REQ: st_q <= present ? LD_WAIT : LD_DONE;
                LD_WAIT: begin
                    word_q[idx_q] <= nv_rdata;
                    idx_q <= idx_q + 2'h1;
                    st_q <= (idx_q == CW_BAUD) ? LD_DONE : LD_REQ;
                end
                LD_DONE: ok <= ok_w && present;
            endcase
        end
    end
    assign done = (st_q == LD_DONE);
    assign flags = word_q[CW_FLAGS][7:0];
    assign baud = word_q[CW_BAUD][7:0];
endmodule
`default_nettype wire

// File: verif/cmg_can_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmg_can_model (
    input wire logic clock,
    input wire logic srst,
    input wire logic stall,
    input wire logic can_tx_valid,
    output logic can_tx_ready,
    input wire logic [28:0] can_tx_id,
    input wire logic [63:0] can_tx_data,
    output logic [7:0] n_tx,
    output logic [28:0] last_id,
    output logic [63:0] last_data,
    input wire logic rx_go,
    input wire logic [28:0] rx_id,
    input wire logic rx_ide,
    output logic can_rx_valid,
    input wire logic can_rx_ready,
    output logic [28:0] can_rx_id,
    output logic can_rx_ide,
    output logic [3:0] can_rx_dlc,
    output logic [63:0] can_rx_data
);
    // Sole node facing the gateway; confirms a frame only by ready
    assign can_tx_ready = !stall;
    always_ff @(posedge clock) begin
        if (srst) begin
            n_tx <= 8'h00;
            last_id <= 29'h0;
            last_data <= 64'h0;
        end else if (can_tx_valid && can_tx_ready) begin
            n_tx <= n_tx + 8'h01;
            last_id <= can_tx_id;
            last_data <= can_tx_data;
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            can_rx_valid <= 1'b0;
            can_rx_id <= 29'h0;
            can_rx_ide <= 1'b0;
            can_rx_dlc <= 4'h0;
            can_rx_data <= 64'h0;
        end else if (rx_go) begin
            can_rx_valid <= 1'b1;
            can_rx_id <= rx_id;
            can_rx_ide <= rx_ide;
            can_rx_dlc <= 4'h8;
            can_rx_data <= 64'h1122334455667788;
        end else if (can_rx_valid && can_rx_ready) begin
            // Released id, dlc and data lines flip so stale fields never look fresh
            can_rx_valid <= 1'b0;
            can_rx_id <= ~can_rx_id;
            can_rx_dlc <= ~can_rx_dlc;
            can_rx_data <= ~can_rx_data;
        end
    end
endmodule
`default_nettype wire

// File: verif/can_master_transparent_gateway_tb.sv
`timescale 1ns/1ps
`default_nettype none
module can_master_transparent_gateway_tb import cmg_pkg::*; ;
    typedef struct {logic [7:0] baud; logic [15:0] kbps; logic en;} cmg_row_s;
    logic clock, srst, mode_pin, nv_present_pin, nv_rd, reg_wr, reg_rd;
    logic [1:0] nv_addr;
    logic [15:0] nv_rdata, can_baud_kbps;
    logic [15:0] img [3];
    logic [7:0] reg_addr, n_tx;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic can_tx_valid, can_tx_ready, can_rx_valid, can_rx_ready, can_rx_ide;
    logic rx_go, rx_ide, stall, can_bus_off, can_err_warn, can_enable, g;
    logic md_green, md_red;
    logic [28:0] can_tx_id, can_rx_id, last_id, rx_id;
    logic [3:0] can_rx_dlc, can_tx_dlc;
    logic [63:0] can_tx_data, can_rx_data, last_data;
    int fails, n_compared, t;
    cmg_row_s rows [10] = '{'{8'h00, 16'h03E8, 1'b1},
        '{8'h01, 16'h0320, 1'b1}, '{8'h02, 16'h01F4, 1'b1},
        '{8'h03, 16'h00FA, 1'b1}, '{8'h04, 16'h007D, 1'b1},
        '{8'h05, 16'h0064, 1'b1}, '{8'h06, 16'h0032, 1'b1},
        '{8'h07, 16'h0014, 1'b1}, '{8'h08, 16'h000A, 1'b1},
        '{8'h09, 16'h0000, 1'b0}};

    cmg_gateway #(.BLINK_CYC(4)) u_dut (.clock(clock), .srst(srst),
        .mode_pin(mode_pin), .nv_present_pin(nv_present_pin), .nv_rd(nv_rd),
        .nv_addr(nv_addr), .nv_rdata(nv_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .can_tx_valid(can_tx_valid),
        .can_tx_ready(can_tx_ready), .can_tx_id(can_tx_id), .can_tx_ide(),
        .can_tx_rtr(), .can_tx_dlc(can_tx_dlc), .can_tx_data(can_tx_data),
        .can_rx_valid(can_rx_valid), .can_rx_ready(can_rx_ready),
        .can_rx_id(can_rx_id), .can_rx_ide(can_rx_ide), .can_rx_rtr(1'b0),
        .can_rx_dlc(can_rx_dlc), .can_rx_data(can_rx_data),
        .can_bus_off(can_bus_off), .can_err_warn(can_err_warn),
        .can_enable(can_enable), .can_baud_kbps(can_baud_kbps),
        .md_green(md_green), .md_red(md_red));
    cmg_can_model u_can (.clock(clock), .srst(srst), .stall(stall),
        .can_tx_valid(can_tx_valid), .can_tx_ready(can_tx_ready),
        .can_tx_id(can_tx_id), .can_tx_data(can_tx_data), .n_tx(n_tx),
        .last_id(last_id), .last_data(last_data), .rx_go(rx_go),
        .rx_id(rx_id), .rx_ide(rx_ide), .can_rx_valid(can_rx_valid),
        .can_rx_ready(can_rx_ready), .can_rx_id(can_rx_id),
        .can_rx_ide(can_rx_ide), .can_rx_dlc(can_rx_dlc),
        .can_rx_data(can_rx_data));

    // Storage answers the cycle after a strobe; otherwise the lines churn
    always @(posedge clock) begin
        nv_rdata <= srst ? '0 :
            (nv_rd && nv_present_pin) ? img[nv_addr] : ~nv_rdata;
    end

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] e,
                       input logic [63:0] s);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic boot(input logic pres, input logic mode,
                        input logic [7:0] flags, input logic [7:0] baud);
        img[0] = CFG_MAGIC;
        img[1] = {8'h00, flags};
        img[2] = {8'h00, baud};
        @(posedge clock);
        srst <= 1'b1;
        mode_pin <= mode;
        nv_present_pin <= pres;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        repeat (30) @(posedge clock);
        #1;
    endtask

    // Eight data bytes behind an 11-bit id; record closes with bseq
    task automatic send(input logic [3:0] seq, input logic [3:0] bseq);
        wr(A_TXA, {16'h0000, IDB11 + DLC_MAX, CMD_SEND, 4'h0, seq});
        wr(A_TXID, {20'h00000, 8'h12, seq});
        wr(A_TXD0, 32'h44332211);
        wr(A_TXD1, 32'h88776655);
        wr(A_TXB, {24'h000000, 4'h0, bseq});
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic rxf(input logic [28:0] id, input logic ide);
        @(posedge clock);
        rx_go <= 1'b1;
        rx_id <= id;
        rx_ide <= ide;
        @(posedge clock);
        rx_go <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    initial begin
        #(8 * 20000);
        fails++;
        results;
    end

    initial begin
        {srst, mode_pin, nv_present_pin, reg_wr, reg_rd} = 5'b10100;
        {rx_go, rx_ide, stall, can_bus_off, can_err_warn} = 5'b00000;
        {reg_addr, reg_wdata, rx_id} = '0;
        fails = 0;
        n_compared = 0;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        #1 chk("enable in reset", 0, can_enable);
        for (int i = 0; i < 10; i++) begin
            boot(1'b1, 1'b0, 8'h00, rows[i].baud);
            chk("kbps", rows[i].kbps, can_baud_kbps);
            chk("enable", rows[i].en, can_enable);
        end
        rd(8'hFC);
        chk("unmapped", 0, v);
        boot(1'b0, 1'b0, 8'h00, 8'h00);
        chk("enable absent", 0, can_enable);
        rd(A_STAT);
        chk("cfg ok absent", 0, v[ST_OK]);
        t = 0;
        repeat (8) begin
            @(posedge clock);
            #1 t += md_red;
        end
        chk("red flash", 4, t);
        boot(1'b1, 1'b1, 8'h00, 8'h00);
        chk("enable cfg mode", 0, can_enable);
        g = md_green;
        t = 0;
        repeat (20) begin
            @(posedge clock);
            #1;
            if (md_green !== g) t++;
            g = md_green;
        end
        chk("blink toggles", 1, t inside {[4:6]});
        @(posedge clock);
        mode_pin <= 1'b0;
        repeat (10) @(posedge clock);
        rd(A_STAT);
        chk("mode latched", 1, v[ST_MODE]);
        // Halt bit set but its evaluation is off, so it is ignored
        boot(1'b1, 1'b0, 8'h00, 8'h02);
        wr(A_CTRL, 32'h00000001);
        send(4'h0, 4'h0);
        chk("tx count", 1, n_tx);
        chk("tx id", 29'h120, last_id);
        chk("tx data", 64'h8877665544332211, last_data);
        chk("tx dlc", DLC_MAX, can_tx_dlc);
        send(4'h1, 4'h2);
        chk("tx inconsistent", 1, n_tx);
        boot(1'b1, 1'b0, 8'h01, 8'h02);
        wr(A_CTRL, 32'h00000001);
        send(4'h0, 4'h0);
        chk("tx halted", 0, n_tx);
        wr(A_CTRL, 32'h00000000);
        send(4'h1, 4'h1);
        chk("tx after halt", 1, n_tx);
        boot(1'b1, 1'b0, 8'h04, 8'h02);
        @(posedge clock);
        stall <= 1'b1;
        send(4'h0, 4'h0);
        chk("held valid", 1, can_tx_valid);
        chk("held id", 29'h120, can_tx_id);
        @(posedge clock);
        stall <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk("confirmed taken", 1, n_tx);
        rd(A_RXA);
        chk("ack echo", 0, v[7:4]);
        send(4'h0, 4'h0);
        chk("repeat refused", 1, n_tx);
        send(4'h1, 4'h1);
        chk("next taken", 2, n_tx);
        rxf(29'h055, 1'b0);
        rxf(29'h066, 1'b0);
        rd(A_RXID);
        chk("rx held", 29'h055, v);
        send(4'h2, 4'h2);
        rd(A_RXID);
        chk("rx after echo", 29'h066, v);
        // 11-bit frames refused, 29-bit frames all accepted
        boot(1'b1, 1'b0, 8'h20, 8'h02);
        rxf(29'h055, 1'b0);
        rd(A_RXA);
        chk("rx 11 dropped", SEQ_RST, v[3:0]);
        rxf(29'h0ABCDEF0, 1'b1);
        rd(A_RXA);
        chk("rx seq", 0, v[3:0]);
        chk("rx cmd", CMD_RXD, v[11:8]);
        chk("rx len", IDB29 + DLC_MAX, v[15:12]);
        rd(A_RXID);
        chk("rx id", 29'h0ABCDEF0, v);
        rd(A_RXD1);
        chk("rx data", 32'h11223344, v);
        @(posedge clock);
        can_bus_off <= 1'b1;
        can_err_warn <= 1'b1;
        rd(A_STAT);
        chk("bus off warn", 2'h3, v[ST_WARN:ST_BOFF]);
        results;
    end
endmodule
`default_nettype wire
